// ---- contactless_cmd_irq_control.sv ----
// Command control and interrupt request logic of the contactless unit
//
// Functional notes
// - Receiver-off bit disables analog receive path
// - Power-save write 1 enters low power
// - Power-save write 0 wakes; reads 1 meanwhile
// - Power-save set ignored during software reinit
// - Command write launches; read returns running code
// - Transmit, receive, alert enables route to line one
// - Idle, fault, timer enables route to line zero
// - Misc enables gate five flags onto line zero
// - Request write bit 7 selects set or clear
// - Transmit flag sets after last bit sent
// - Receive flag sets on valid end, optionally bytes
// - Idle flag sets when command ends itself
// - Unknown command reverts idle, sets idle flag
// - Processor idle write does not set idle flag
// - High-alert flag latches; cleared only by write
// - Low-alert flag latches; cleared only by write
// - Fault flag sets when any error bit set
// - Timer flag sets when countdown reaches zero
// - Dynamic bits writable and updated by hardware
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module contactless_cmd_irq_control
  import irq_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire common_events_type common_events,
  input wire misc_events_type misc_events,
  input wire logic [7:0] error_status_register,
  input wire logic receive_requires_bytes,
  input wire logic [15:0] known_command_mask,
  output logic receiver_analog_off,
  output logic analog_power_save,
  output logic [3:0] active_command,
  output logic command_launch,
  output logic interrupt_line_zero,
  output logic interrupt_line_one
);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] index);
    hit = (addr == {2'b00, index, 2'b00});
  endfunction

  logic access;
  logic wr;
  logic mapped;
  logic [7:0] wbyte;

  assign access = psel && penable;
  assign wr = access && pwrite;
  assign wbyte = pwdata[7:0];
  assign mapped = hit(paddr, CMD_INDEX) || hit(paddr, COMMON_ENABLE_INDEX)
    || hit(paddr, MISC_ENABLE_INDEX) || hit(paddr, COMMON_REQUEST_INDEX)
    || hit(paddr, MISC_REQUEST_INDEX) || hit(paddr, EVENT_STATUS_INDEX);
  // Every register answers at once, so no wait states
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  logic wr_cmd;
  logic wr_common_en;
  logic wr_misc_en;
  logic wr_common_req;
  logic wr_misc_req;

  assign wr_cmd = wr && hit(paddr, CMD_INDEX);
  assign wr_common_en = wr && hit(paddr, COMMON_ENABLE_INDEX);
  assign wr_misc_en = wr && hit(paddr, MISC_ENABLE_INDEX);
  assign wr_common_req = wr && hit(paddr, COMMON_REQUEST_INDEX);
  assign wr_misc_req = wr && hit(paddr, MISC_REQUEST_INDEX);

  // ----------------------------------------
  // Command register
  // ----------------------------------------
  logic [3:0] command_code;
  logic unknown_revert;
  logic self_finish;

  // An unknown code shows for one cycle, then reverts and raises the idle flag
  assign unknown_revert = (command_code != CMD_IDLE) && !known_command_mask[command_code];
  assign self_finish = common_events.command_self_done && (command_code != CMD_IDLE);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      receiver_analog_off <= CMD_RESET[RCV_OFF_BIT];
    else if (wr_cmd)
      receiver_analog_off <= wbyte[RCV_OFF_BIT];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      command_code <= CMD_RESET[CMD_MSB:0];
    else if (wr_cmd)
      command_code <= wbyte[CMD_MSB:0];
    else if (unknown_revert || self_finish)
      command_code <= CMD_IDLE;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      command_launch <= 1'b0;
    else
      // Unknown codes never launch, so the sequencer cannot start one
      command_launch <= wr_cmd && known_command_mask[wbyte[CMD_MSB:0]];
  end

  assign active_command = command_code;

  // ----------------------------------------
  // Power save and wake-up
  // ----------------------------------------
  power_state_type power_state;
  logic [WAKE_W-1:0] wake_count;
  logic save_request;

  // Reinit running blocks entry; the written code also counts if it is reinit
  assign save_request = wr_cmd && wbyte[POWER_SAVE_BIT]
    && (command_code != CMD_SOFT_REINIT) && (wbyte[CMD_MSB:0] != CMD_SOFT_REINIT);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      power_state <= PWR_ACTIVE;
      wake_count <= '0;
    end
    else
    begin
      unique case (power_state)
        PWR_ACTIVE:
          if (save_request)
            power_state <= PWR_SAVE;
        PWR_SAVE:
          if (wr_cmd && !wbyte[POWER_SAVE_BIT])
          begin
            power_state <= PWR_WAKING;
            wake_count <= WAKE_W'(WAKE_CYCLES - 1);
          end
        PWR_WAKING:
          if (save_request)
            power_state <= PWR_SAVE;
          else if (wake_count == '0)
            power_state <= PWR_ACTIVE;
          else
            wake_count <= wake_count - 1'b1;
      endcase
    end
  end

  // Front end stays powered while waking so it is settled on release;
  // follows the same transitions as the state register, one flop later never
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      analog_power_save <= 1'b0;
    else if (save_request && (power_state != PWR_SAVE))
      analog_power_save <= 1'b1;
    else if ((power_state == PWR_SAVE) && wr_cmd && !wbyte[POWER_SAVE_BIT])
      analog_power_save <= 1'b0;
  end

  logic power_bit_read;
  assign power_bit_read = (power_state != PWR_ACTIVE);

  // ----------------------------------------
  // Enable registers
  // ----------------------------------------
  logic [6:0] common_enable;
  logic [4:0] misc_enable;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      common_enable <= COMMON_ENABLE_RESET;
    else if (wr_common_en)
      common_enable <= wbyte[6:0];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      misc_enable <= MISC_ENABLE_RESET;
    else if (wr_misc_en)
      misc_enable <= wbyte[4:0] & MISC_MASK;
  end

  // ----------------------------------------
  // Hardware event detection
  // ----------------------------------------
  logic high_prev;
  logic low_prev;
  logic timer_prev;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      high_prev <= 1'b0;
      low_prev <= 1'b0;
      timer_prev <= 1'b0;
    end
    else
    begin
      high_prev <= common_events.fifo_high_warning_live;
      low_prev <= common_events.fifo_low_warning_live;
      timer_prev <= common_events.countdown_at_zero;
    end
  end

  logic [6:0] hw_set;

  always_comb
  begin
    hw_set = '0;
    hw_set[TX_BIT] = common_events.tx_last_bit_sent;
    hw_set[RX_BIT] = common_events.rx_valid_end
      && (!receive_requires_bytes || common_events.rx_fifo_has_bytes);
    // Processor idle write never reaches self_finish or unknown_revert
    hw_set[IDLE_BIT] = !wr_cmd && (self_finish || unknown_revert);
    hw_set[HIGH_BIT] = common_events.fifo_high_warning_live && !high_prev;
    hw_set[LOW_BIT] = common_events.fifo_low_warning_live && !low_prev;
    // Re-set every cycle while errors stand, so a clear sticks only once they go
    hw_set[FAULT_BIT] = |error_status_register;
    hw_set[TIMER_BIT] = common_events.countdown_at_zero && !timer_prev;
  end

  // ----------------------------------------
  // Request flags
  // ----------------------------------------
  logic [6:0] common_request;
  logic [4:0] misc_request;

  // Shared set/clear update; hardware set wins over a clearing write
  function automatic logic [6:0] update_flags(input logic [6:0] cur, input logic [6:0] hw,
    input logic we, input logic [7:0] data);
    logic [6:0] res;
    res = cur;
    if (we)
    begin
      if (data[SET_SELECT_BIT])
        res = cur | data[6:0];
      else
        res = cur & ~data[6:0];
    end
    update_flags = res | hw;
  endfunction

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      common_request <= COMMON_REQUEST_RESET;
    else
      common_request <= update_flags(common_request, hw_set, wr_common_req, wbyte);
  end

  // Padded so the misc flags share the set/clear update
  logic [6:0] misc_next;
  assign misc_next = update_flags({2'b00, misc_request}, {2'b00, misc_events},
    wr_misc_req, wbyte);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      misc_request <= MISC_REQUEST_RESET;
    else
      misc_request <= misc_next[4:0];
  end

  // ----------------------------------------
  // Interrupt lines
  // ----------------------------------------
  logic [6:0] routed;
  logic line_one_any;
  logic line_zero_common;
  logic line_zero_misc;

  assign routed = common_request & common_enable;
  assign line_one_any = |(routed & LINE_ONE_ROUTE);
  assign line_zero_common = |(routed & LINE_ZERO_ROUTE);
  assign line_zero_misc = |(misc_request & misc_enable);

  // Registered so the lines never glitch; they trail the flags by one edge
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      interrupt_line_one <= 1'b0;
      interrupt_line_zero <= 1'b0;
    end
    else
    begin
      interrupt_line_one <= line_one_any;
      interrupt_line_zero <= line_zero_common || line_zero_misc;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [7:0] rbyte;

  always_comb
  begin
    rbyte = '0;
    if (hit(paddr, CMD_INDEX))
      rbyte = {2'b00, receiver_analog_off, power_bit_read, command_code};
    else if (hit(paddr, COMMON_ENABLE_INDEX))
      rbyte = {1'b0, common_enable};
    else if (hit(paddr, MISC_ENABLE_INDEX))
      rbyte = {3'b000, misc_enable};
    else if (hit(paddr, COMMON_REQUEST_INDEX))
      rbyte = {1'b0, common_request};
    else if (hit(paddr, MISC_REQUEST_INDEX))
      rbyte = {3'b000, misc_request};
    else if (hit(paddr, EVENT_STATUS_INDEX))
      rbyte = {5'b00000, power_state};
  end

  // Taken in the setup cycle so read data stands through the access phase
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
      prdata <= {24'h000000, rbyte};
  end

endmodule

// ---- irq_ctrl_pkg.sv ----
// Package: register map, field positions, reset values, types for command/interrupt control
package irq_ctrl_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] CMD_INDEX = 8'hD1;
  localparam logic [7:0] COMMON_ENABLE_INDEX = 8'hD2;
  localparam logic [7:0] MISC_ENABLE_INDEX = 8'hD3;
  localparam logic [7:0] COMMON_REQUEST_INDEX = 8'hD4;
  localparam logic [7:0] MISC_REQUEST_INDEX = 8'hD5;
  localparam logic [7:0] EVENT_STATUS_INDEX = 8'hE0;

  localparam int ADDR_W = 12;

  // Command register fields
  localparam int RCV_OFF_BIT = 5;
  localparam int POWER_SAVE_BIT = 4;
  localparam int CMD_MSB = 3;
  localparam logic [7:0] CMD_RESET = 8'h20;

  // Command codes
  localparam logic [3:0] CMD_IDLE = 4'h0;
  localparam logic [3:0] CMD_SOFT_REINIT = 4'hF;

  // Flag positions in common request / enable
  localparam int SET_SELECT_BIT = 7;
  localparam int TX_BIT = 6;
  localparam int RX_BIT = 5;
  localparam int IDLE_BIT = 4;
  localparam int HIGH_BIT = 3;
  localparam int LOW_BIT = 2;
  localparam int FAULT_BIT = 1;
  localparam int TIMER_BIT = 0;

  localparam logic [6:0] LINE_ONE_ROUTE = 7'h6C;
  localparam logic [6:0] LINE_ZERO_ROUTE = 7'h13;
  localparam logic [4:0] MISC_MASK = 5'h1F;

  localparam logic [6:0] COMMON_REQUEST_RESET = 7'h14;
  localparam logic [6:0] COMMON_ENABLE_RESET = 7'h00;
  localparam logic [4:0] MISC_ENABLE_RESET = 5'h00;
  localparam logic [4:0] MISC_REQUEST_RESET = 5'h00;

  // Wake-up time and derived cycles
  localparam int CLK_HZ = 25000000;
  localparam int WAKE_US = 10;
  localparam int WAKE_CYCLES = (WAKE_US * (CLK_HZ / 1000000));
  localparam int WAKE_W = 9;

  typedef struct packed {
    logic tx_last_bit_sent;
    logic rx_valid_end;
    logic rx_fifo_has_bytes;
    logic command_self_done;
    logic fifo_high_warning_live;
    logic fifo_low_warning_live;
    logic countdown_at_zero;
  } common_events_type;

  typedef struct packed {
    logic signal_input_edge;
    logic mode_detected;
    logic checksum_done;
    logic field_on;
    logic field_off;
  } misc_events_type;

  typedef enum logic [2:0] {
    PWR_ACTIVE = 3'b001,
    PWR_SAVE = 3'b010,
    PWR_WAKING = 3'b100
  } power_state_type;

endpackage

// ---- contactless_cmd_irq_control_checker.sv ----
// Port-level checker for command and interrupt control
`timescale 1ns/1ps
module contactless_cmd_irq_control_checker
  import irq_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire common_events_type common_events,
  input wire misc_events_type misc_events,
  input wire logic [7:0] error_status_register,
  input wire logic receive_requires_bytes,
  input wire logic [15:0] known_command_mask,
  input wire logic receiver_analog_off,
  input wire logic analog_power_save,
  input wire logic [3:0] active_command,
  input wire logic command_launch,
  input wire logic interrupt_line_zero,
  input wire logic interrupt_line_one
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ----
  // Decode
  // ----
  logic acc;
  logic cmd_wr;
  logic mapped;
  logic known;
  assign acc = psel && penable;
  assign cmd_wr = acc && pwrite && paddr == {2'b00, CMD_INDEX, 2'b00};
  assign mapped = paddr[11:10] == 2'b00 && paddr[1:0] == 2'b00
    && (paddr[9:2] inside {[CMD_INDEX:MISC_REQUEST_INDEX], EVENT_STATUS_INDEX});
  assign known = pwdata[3:0] != CMD_IDLE && known_command_mask[pwdata[3:0]];
  sequence launch_pulse;
    command_launch ##1 !command_launch;
  endsequence
  sequence stays_awake;
    !analog_power_save ##1 !analog_power_save;
  endsequence
  chk_cmd_code: assert property (cmd_wr |=> active_command == $past(pwdata[3:0]))
    else $error("command code not taken");
  chk_rcv_follow: assert property (cmd_wr |=> receiver_analog_off == $past(pwdata[5]))
    else $error("receiver off bit not taken");
  chk_launch_known: assert property (cmd_wr && known |=> launch_pulse)
    else $error("launch pulse missing");
  chk_unknown_revert: assert property (cmd_wr && pwdata[3:0] != CMD_IDLE && !known
    |=> ##1 active_command == CMD_IDLE) else $error("unknown code kept");
  chk_save_enter: assert property (cmd_wr && pwdata[4] && pwdata[3:0] != CMD_SOFT_REINIT
    && active_command != CMD_SOFT_REINIT |=> analog_power_save) else $error("no power save");
  chk_reinit_block: assert property (cmd_wr && pwdata[4] && !analog_power_save
    && (pwdata[3:0] == CMD_SOFT_REINIT || active_command == CMD_SOFT_REINIT)
    |=> !analog_power_save) else $error("power save during reinit");
  chk_wake_start: assert property (cmd_wr && !pwdata[4] && analog_power_save
    |=> stays_awake) else $error("wake not started");
  chk_unmapped_err: assert property (acc && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  chk_lines_reset: assert property ($rose(reset_n) |-> !interrupt_line_zero
    && !interrupt_line_one) else $error("line high after reset");
endmodule

// ---- contactless_cmd_irq_control_tb_top.sv ----
// Self-checking bench for command and interrupt control
`timescale 1ns/1ps
module contactless_cmd_irq_control_tb_top
  import irq_ctrl_pkg::*;
;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  common_events_type common_events;
  misc_events_type misc_events;
  logic [7:0] error_status_register;
  logic receive_requires_bytes, receiver_analog_off, analog_power_save, command_launch;
  logic [15:0] known_command_mask;
  logic [3:0] active_command;
  logic interrupt_line_zero, interrupt_line_one;
  int n_fail, compares;
  localparam logic [6:0] ONE_MAP = 7'h6C;
  localparam logic [6:0] ZERO_MAP = 7'h13;
  contactless_cmd_irq_control u_dut (
    .clk(clk),
    .reset_n(reset_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .common_events(common_events),
    .misc_events(misc_events),
    .error_status_register(error_status_register),
    .receive_requires_bytes(receive_requires_bytes),
    .known_command_mask(known_command_mask),
    .receiver_analog_off(receiver_analog_off),
    .analog_power_save(analog_power_save),
    .active_command(active_command),
    .command_launch(command_launch),
    .interrupt_line_zero(interrupt_line_zero),
    .interrupt_line_one(interrupt_line_one)
  );
  // ----
  // Tasks
  // ----
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    cmp(rd, {24'h000000, exp});
  endtask
  task automatic ev(input common_events_type v);
    @(posedge clk);
    common_events <= v;
    @(posedge clk);
    common_events <= '0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic end_of_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----
  // Stimulus
  // ----
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    #(40 * 5000);
    n_fail++;
    end_of_test();
  end
  initial
  begin
    {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
    common_events = '0;
    misc_events = '0;
    error_status_register = 8'h00;
    receive_requires_bytes = 1'b1;
    known_command_mask = 16'h80FE;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rdc(COMMON_ENABLE_INDEX, 8'h00);
    rdc(MISC_ENABLE_INDEX, 8'h00);
    rdc(COMMON_REQUEST_INDEX, 8'h14);
    rdc(CMD_INDEX, 8'h20);
    bus(1'b0, 8'hD0, 8'h00);
    cmp(err, 1);
    wr(MISC_ENABLE_INDEX, 8'hFF);
    rdc(MISC_ENABLE_INDEX, 8'h1F);
    wr(COMMON_REQUEST_INDEX, 8'h7F);
    rdc(COMMON_REQUEST_INDEX, 8'h00);
    wr(COMMON_REQUEST_INDEX, 8'hC1);
    wr(COMMON_REQUEST_INDEX, 8'h40);
    rdc(COMMON_REQUEST_INDEX, 8'h01);
    wr(COMMON_REQUEST_INDEX, 8'h01);
    ev(7'h20);
    rdc(COMMON_REQUEST_INDEX, 8'h00);
    ev(7'h30);
    ev(7'h40);
    ev(7'h06);
    ev(7'h01);
    rdc(COMMON_REQUEST_INDEX, 8'h6D);
    error_status_register <= 8'h80;
    tick(2);
    error_status_register <= 8'h00;
    rdc(COMMON_REQUEST_INDEX, 8'h6F);
    wr(COMMON_REQUEST_INDEX, 8'h7F);
    wr(CMD_INDEX, 8'h03);
    rdc(CMD_INDEX, 8'h03);
    cmp(receiver_analog_off, 0);
    ev(7'h08);
    rdc(CMD_INDEX, 8'h00);
    rdc(COMMON_REQUEST_INDEX, 8'h10);
    wr(COMMON_REQUEST_INDEX, 8'h10);
    wr(CMD_INDEX, 8'h09);
    rdc(CMD_INDEX, 8'h00);
    rdc(COMMON_REQUEST_INDEX, 8'h10);
    wr(COMMON_REQUEST_INDEX, 8'h10);
    wr(CMD_INDEX, 8'h03);
    wr(CMD_INDEX, 8'h00);
    rdc(CMD_INDEX, 8'h00);
    rdc(COMMON_REQUEST_INDEX, 8'h00);
    for (int i = 0; i < 7; i++)
    begin
      wr(COMMON_ENABLE_INDEX, 8'h01 << i);
      wr(COMMON_REQUEST_INDEX, 8'h80 | (8'h01 << i));
      tick(2);
      cmp(interrupt_line_one, ONE_MAP[i]);
      cmp(interrupt_line_zero, ZERO_MAP[i]);
      wr(COMMON_REQUEST_INDEX, 8'h01 << i);
      tick(2);
      cmp({interrupt_line_one, interrupt_line_zero}, 0);
    end
    wr(COMMON_ENABLE_INDEX, 8'h00);
    wr(COMMON_REQUEST_INDEX, 8'hFF);
    tick(2);
    cmp({interrupt_line_one, interrupt_line_zero}, 0);
    for (int i = 0; i < 5; i++)
    begin
      wr(MISC_ENABLE_INDEX, 8'h01 << i);
      @(posedge clk);
      misc_events <= 5'h01 << i;
      @(posedge clk);
      misc_events <= '0;
      tick(2);
      cmp(interrupt_line_zero, 1);
      wr(MISC_REQUEST_INDEX, 8'h01 << i);
      tick(2);
      cmp(interrupt_line_zero, 0);
    end
    wr(CMD_INDEX, 8'h10);
    rdc(CMD_INDEX, 8'h10);
    cmp(analog_power_save, 1);
    wr(CMD_INDEX, 8'h00);
    rdc(CMD_INDEX, 8'h10);
    cmp(analog_power_save, 0);
    tick(WAKE_CYCLES - 10);
    rdc(CMD_INDEX, 8'h10);
    tick(10);
    rdc(CMD_INDEX, 8'h00);
    wr(CMD_INDEX, 8'h0F);
    wr(CMD_INDEX, 8'h1F);
    rdc(CMD_INDEX, 8'h0F);
    cmp(analog_power_save, 0);
    wr(CMD_INDEX, 8'h00);
    end_of_test();
  end
endmodule

bind contactless_cmd_irq_control contactless_cmd_irq_control_checker u_chk (
  .clk(clk),
  .reset_n(reset_n),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .common_events(common_events),
  .misc_events(misc_events),
  .error_status_register(error_status_register),
  .receive_requires_bytes(receive_requires_bytes),
  .known_command_mask(known_command_mask),
  .receiver_analog_off(receiver_analog_off),
  .analog_power_save(analog_power_save),
  .active_command(active_command),
  .command_launch(command_launch),
  .interrupt_line_zero(interrupt_line_zero),
  .interrupt_line_one(interrupt_line_one)
);
